/* File: core/charger_pkg.sv */
// Shared constants, timing counts and state types for the charger sequencer
package charger_pkg;

   // ----------------------------------------------------------------------
   // Clock and documented times
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_FREQ_MHZ = 125;
   localparam int unsigned SW_FREQ_KHZ = 300;
   localparam int unsigned DETECT_DELAY_US = 200;
   localparam int unsigned DEGLITCH_US = 2000;
   localparam int unsigned SS_STEP_US = 1000;
   localparam int unsigned DEAD_TIME_NS = 30;
   localparam int unsigned RECHARGE_NS = 80;

   // ----------------------------------------------------------------------
   // Cycle counts derived from the times
   // ----------------------------------------------------------------------
   localparam int unsigned DETECT_CYC = DETECT_DELAY_US * CLK_FREQ_MHZ;
   localparam int unsigned DEGLITCH_CYC = DEGLITCH_US * CLK_FREQ_MHZ;
   localparam int unsigned SS_STEP_CYC = SS_STEP_US * CLK_FREQ_MHZ;
   // Period rounds down: 416 cycles, about 300.5 kHz
   localparam int unsigned PERIOD_CYC = (CLK_FREQ_MHZ * 1000) / SW_FREQ_KHZ;
   // Dead time is a least time, so it rounds up
   localparam int unsigned DEAD_CYC = (DEAD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned RECHARGE_CYC = (RECHARGE_NS * CLK_FREQ_MHZ) / 1000;

   // ----------------------------------------------------------------------
   // Widths and sized compare values
   // ----------------------------------------------------------------------
   localparam int unsigned TMR_W = 18;
   localparam int unsigned PER_W = 9;
   localparam int unsigned GCNT_W = 4;
   localparam logic [PER_W-1:0] PERIOD_LAST = PER_W'(PERIOD_CYC - 1);
   localparam logic [GCNT_W-1:0] DEAD_LAST = GCNT_W'(DEAD_CYC - 1);
   localparam logic [GCNT_W-1:0] RECHARGE_LAST = GCNT_W'(RECHARGE_CYC - 1);
   localparam logic [3:0] SS_STEPS = 4'h8;
   localparam logic [2:0] BOOT_LOW_CYC = 3'h3;

   // ----------------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_OFF = 3'b000,
      SEQ_DETECT = 3'b001,
      SEQ_READY = 3'b010,
      SEQ_DEGLITCH = 3'b011,
      SEQ_CHARGE = 3'b100
   } seq_state_type;

   typedef enum logic [2:0] {
      G_OFF = 3'b000,
      G_HIGH = 3'b001,
      G_DEAD_LO = 3'b010,
      G_LOW = 3'b011,
      G_DEAD_HI = 3'b100
   } gate_state_type;

endpackage

/* File: core/timer_if.sv */
// Clear and expiry pair between the sequencer and one interval timer
`timescale 1ns/1ps
`default_nettype none

interface timer_if;
   logic clear;
   logic expired;

   modport owner (output clear, input expired);
   modport timer (input clear, output expired);
endinterface

`default_nettype wire

/* File: core/interval_timer.sv */
// Interval timer: counts cycles while not cleared, holds expiry at the limit
`timescale 1ns/1ps
`default_nettype none

module interval_timer
   import charger_pkg::*;
#(
   parameter int unsigned LIMIT = 16
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Control pair
   timer_if.timer tif
);

   localparam logic [TMR_W-1:0] LAST = TMR_W'(LIMIT - 1);

   logic [TMR_W-1:0] cnt_r;
   logic [TMR_W-1:0] cnt_nxt;

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------
   // Saturating at the last count keeps expiry high until the owner clears
   always_comb begin
      if (tif.clear) begin
         cnt_nxt = '0;
      end else if (cnt_r != LAST) begin
         cnt_nxt = cnt_r + 1'b1;
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tif.expired = (cnt_r == LAST);

endmodule

`default_nettype wire

/* File: core/sync_mode_select.sv */
// Synchronous versus diode-emulation mode choice with comparator hysteresis
`timescale 1ns/1ps
`default_nettype none

module sync_mode_select (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Switching cycle boundary
   input wire logic period_start_i,
   // Charge-current comparator results
   input wire logic cur_below_fall_i,
   input wire logic cur_above_rise_i,
   // Mode
   output logic sync_mode_o
);

   logic mode_r;
   logic mode_nxt;

   // ----------------------------------------------------------------------
   // Mode latch
   // ----------------------------------------------------------------------
   // Mode only changes at a cycle boundary so a pulse is never cut short
   always_comb begin
      mode_nxt = mode_r;
      if (period_start_i) begin
         if (mode_r && cur_below_fall_i) begin
            mode_nxt = 1'b0;
         end else if (!mode_r && cur_above_rise_i && !cur_below_fall_i) begin
            mode_nxt = 1'b1;
         end
      end
   end

   // Starts in diode emulation, the safe choice at low current
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         mode_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   assign sync_mode_o = mode_r;

endmodule

`default_nettype wire

/* File: core/charger_enable_gate_sequencer.sv */
// Charger power-up sequencing, charge qualification, soft-start and gate drive
`timescale 1ns/1ps
`default_nettype none

module charger_enable_gate_sequencer
   import charger_pkg::*;
#(
   parameter int unsigned DETECT_LIMIT = DETECT_CYC,
   parameter int unsigned DEGLITCH_LIMIT = DEGLITCH_CYC,
   parameter int unsigned SS_STEP_LIMIT = SS_STEP_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Supply and adapter comparators
   input wire logic input_supply_sense_above_4v_i,
   input wire logic adapter_detect_in_above_0p6v_i,
   input wire logic adapter_detect_in_above_2p4v_i,
   input wire logic adapter_above_batt_i,
   input wire logic adapter_ovp_i,
   // Enable and protection
   input wire logic chg_en_pin_i,
   input wire logic gate_supply_ok_i,
   input wire logic ref_ok_i,
   input wire logic thermal_shutdown_i,
   input wire logic charge_ocp_i,
   // Loop and bootstrap comparators
   input wire logic duty_req_i,
   input wire logic boot_low_i,
   input wire logic cur_below_fall_i,
   input wire logic cur_above_rise_i,
   // Bias and monitor controls
   output logic partial_bias_o,
   output logic full_bias_o,
   output logic current_monitor_en_o,
   // Open-drain adapter status
   output logic adapter_ok_out_o,
   output logic adapter_ok_oe_o,
   // Charge status and current limit
   output logic charge_enabled_o,
   output logic [3:0] ss_level_o,
   output logic sync_mode_o,
   // Gate commands
   output logic hs_gate_o,
   output logic ls_gate_o
);

   localparam int PER_CHK = int'(PERIOD_CYC);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   seq_state_type seq_r;
   seq_state_type seq_nxt;
   gate_state_type g_r;
   gate_state_type g_nxt;
   logic adapter_ok_out_r;
   logic adapter_ok_out_nxt;
   logic part_r;
   logic part_nxt;
   logic full_r;
   logic full_nxt;
   logic [3:0] ss_r;
   logic [3:0] ss_nxt;
   logic [PER_W-1:0] per_r;
   logic [PER_W-1:0] per_nxt;
   logic [GCNT_W-1:0] gcnt_r;
   logic [GCNT_W-1:0] gcnt_nxt;
   logic refresh_r;
   logic refresh_nxt;
   logic [2:0] boot_r;
   logic [2:0] boot_nxt;
   logic hs_r;
   logic ls_r;
   logic enable_ok;
   logic charging;
   logic period_start;
   logic refresh_req;
   logic gcnt_inc;

   timer_if det_tif ();
   timer_if deg_tif ();
   timer_if step_tif ();

   // ----------------------------------------------------------------------
   // Interval timers
   // ----------------------------------------------------------------------
   interval_timer #(.LIMIT(DETECT_LIMIT)) u_detect_tmr (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .tif(det_tif.timer)
   );

   interval_timer #(.LIMIT(DEGLITCH_LIMIT)) u_deglitch_tmr (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .tif(deg_tif.timer)
   );

   interval_timer #(.LIMIT(SS_STEP_LIMIT)) u_step_tmr (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .tif(step_tif.timer)
   );

   sync_mode_select u_sync_sel (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .period_start_i(period_start),
      .cur_below_fall_i(cur_below_fall_i),
      .cur_above_rise_i(cur_above_rise_i),
      .sync_mode_o(sync_mode_o)
   );

   // ----------------------------------------------------------------------
   // Power-up sequencing and charge qualification
   // ----------------------------------------------------------------------
   // One term for start and for stop, so the two can never disagree
   assign enable_ok = input_supply_sense_above_4v_i && chg_en_pin_i && adapter_detect_in_above_2p4v_i &&
                      adapter_above_batt_i && gate_supply_ok_i && ref_ok_i &&
                      !thermal_shutdown_i && !adapter_ovp_i && !charge_ocp_i;
   assign charging = (seq_r == SEQ_CHARGE);
   assign det_tif.clear = (seq_r != SEQ_DETECT);
   assign deg_tif.clear = (seq_r != SEQ_DEGLITCH);

   always_comb begin
      seq_nxt = seq_r;
      unique case (seq_r)
         SEQ_OFF: begin
            if (input_supply_sense_above_4v_i && adapter_detect_in_above_2p4v_i) begin
               seq_nxt = SEQ_DETECT;
            end
         end
         SEQ_DETECT: begin
            if (!adapter_detect_in_above_2p4v_i) begin
               seq_nxt = SEQ_OFF;
            end else if (det_tif.expired) begin
               seq_nxt = SEQ_READY;
            end
         end
         SEQ_READY: begin
            if (!adapter_detect_in_above_2p4v_i) begin
               seq_nxt = SEQ_OFF;
            end else if (enable_ok) begin
               seq_nxt = SEQ_DEGLITCH;
            end
         end
         SEQ_DEGLITCH: begin
            // Any other enable drop during the window restarts it from the ready state; adapter detect or supply loss goes to off
            if (!adapter_detect_in_above_2p4v_i) begin
               seq_nxt = SEQ_OFF;
            end else if (!enable_ok) begin
               seq_nxt = SEQ_READY;
            end else if (deg_tif.expired) begin
               seq_nxt = SEQ_CHARGE;
            end
         end
         SEQ_CHARGE: begin
            if (!adapter_detect_in_above_2p4v_i) begin
               seq_nxt = SEQ_OFF;
            end else if (!enable_ok) begin
               seq_nxt = SEQ_READY;
            end
         end
         default: begin
            seq_nxt = SEQ_OFF;
         end
      endcase
      // Supply lockout overrides every state
      if (!input_supply_sense_above_4v_i) begin
         seq_nxt = SEQ_OFF;
      end
   end

   // Status and bias follow the comparators one cycle later
   always_comb begin
      adapter_ok_out_nxt = (seq_nxt == SEQ_READY) || (seq_nxt == SEQ_DEGLITCH) ||
                 (seq_nxt == SEQ_CHARGE);
      part_nxt = input_supply_sense_above_4v_i && !adapter_detect_in_above_0p6v_i;
      full_nxt = input_supply_sense_above_4v_i && adapter_detect_in_above_0p6v_i;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         seq_r <= SEQ_OFF;
         adapter_ok_out_r <= 1'b0;
         part_r <= 1'b0;
         full_r <= 1'b0;
      end else begin
         seq_r <= seq_nxt;
         adapter_ok_out_r <= adapter_ok_out_nxt;
         part_r <= part_nxt;
         full_r <= full_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Soft-start
   // ----------------------------------------------------------------------
   // The step timer rearms itself at each step and stops at the top
   assign step_tif.clear = !charging || step_tif.expired || (ss_r == SS_STEPS);

   always_comb begin
      if (!charging) begin
         ss_nxt = 4'h0;
      end else if (step_tif.expired && (ss_r != SS_STEPS)) begin
         ss_nxt = ss_r + 4'h1;
      end else begin
         ss_nxt = ss_r;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ss_r <= 4'h0;
      end else begin
         ss_r <= ss_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Switching period and bootstrap watch
   // ----------------------------------------------------------------------
   // Free-running so the frequency never depends on operating conditions
   assign period_start = (per_r == '0);
   assign per_nxt = (per_r == PERIOD_LAST) ? '0 : per_r + 1'b1;
   assign refresh_req = (boot_r > BOOT_LOW_CYC);

   always_comb begin
      if ((g_r != G_HIGH) || !boot_low_i) begin
         boot_nxt = 3'h0;
      end else if (period_start && (boot_r != 3'h7)) begin
         boot_nxt = boot_r + 3'h1;
      end else begin
         boot_nxt = boot_r;
      end
   end

   // ----------------------------------------------------------------------
   // Gate sequencing
   // ----------------------------------------------------------------------
   always_comb begin
      g_nxt = g_r;
      gcnt_inc = 1'b1;
      refresh_nxt = refresh_r;
      unique case (g_r)
         G_OFF: begin
            // The saturated count also guards the gap after a short pulse
            if (period_start && duty_req_i && (gcnt_r >= DEAD_LAST)) begin
               g_nxt = G_HIGH;
            end
         end
         G_HIGH: begin
            // A held request never ends the on time at a cycle boundary
            if (refresh_req) begin
               g_nxt = G_DEAD_LO;
               refresh_nxt = 1'b1;
            end else if (!duty_req_i) begin
               g_nxt = G_DEAD_LO;
               refresh_nxt = 1'b0;
            end
         end
         G_DEAD_LO: begin
            if (gcnt_r == DEAD_LAST) begin
               g_nxt = G_LOW;
            end
         end
         G_LOW: begin
            if (refresh_r || !sync_mode_o) begin
               if (gcnt_r == RECHARGE_LAST) begin
                  g_nxt = refresh_r ? G_DEAD_HI : G_OFF;
               end
            end else if (period_start) begin
               g_nxt = duty_req_i ? G_DEAD_HI : G_OFF;
            end
         end
         G_DEAD_HI: begin
            if (gcnt_r == DEAD_LAST) begin
               g_nxt = G_HIGH;
               refresh_nxt = 1'b0;
            end
         end
         default: begin
            g_nxt = G_OFF;
         end
      endcase
      if (g_nxt != g_r) begin
         gcnt_inc = 1'b0;
      end
      if (!charging) begin
         g_nxt = G_OFF;
         refresh_nxt = 1'b0;
      end
      if (g_nxt != g_r) begin
         gcnt_nxt = '0;
      end else if (gcnt_inc && (gcnt_r != '1)) begin
         gcnt_nxt = gcnt_r + 1'b1;
      end else begin
         gcnt_nxt = gcnt_r;
      end
   end

   // Gate commands are decoded from the next state to keep them glitch free
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         per_r <= '0;
         g_r <= G_OFF;
         gcnt_r <= '1;
         refresh_r <= 1'b0;
         boot_r <= 3'h0;
         hs_r <= 1'b0;
         ls_r <= 1'b0;
      end else begin
         per_r <= per_nxt;
         g_r <= g_nxt;
         gcnt_r <= gcnt_nxt;
         refresh_r <= refresh_nxt;
         boot_r <= boot_nxt;
         hs_r <= (g_nxt == G_HIGH);
         ls_r <= (g_nxt == G_LOW);
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Status pin only ever pulls low; the external pull-up makes the high
   assign adapter_ok_out_o = 1'b0;
   assign adapter_ok_oe_o = !adapter_ok_out_r;
   assign partial_bias_o = part_r;
   assign full_bias_o = full_r;
   assign current_monitor_en_o = full_r;
   assign charge_enabled_o = charging;
   assign ss_level_o = ss_r;
   assign hs_gate_o = hs_r;
   assign ls_gate_o = ls_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   sequence both_off_gap;
      (!hs_gate_o && !ls_gate_o) [*4];
   endsequence

   // Ten cycles high, split in two runs so no repetition grows long
   sequence recharge_pulse;
      (ls_gate_o || !charging) [*8] ##1 (ls_gate_o || !charging) [*2] ##1 !ls_gate_o;
   endsequence

   input_supply_sense_lockout_a: assert property (
      !input_supply_sense_above_4v_i |=> !charge_enabled_o && adapter_ok_oe_o)
      else $error("charging or status high with supply low");

   partial_bias_a: assert property (
      input_supply_sense_above_4v_i && !adapter_detect_in_above_0p6v_i |=> partial_bias_o && !current_monitor_en_o)
      else $error("monitor active with adapter detect low");

   full_bias_a: assert property (
      input_supply_sense_above_4v_i && adapter_detect_in_above_0p6v_i |=> full_bias_o && current_monitor_en_o)
      else $error("full bias missing with adapter detected");

   adapter_ok_out_delay_a: assert property (
      $fell(adapter_ok_oe_o) |-> $past(det_tif.expired && adapter_detect_in_above_2p4v_i))
      else $error("status released before detect delay");

   deglitch_wait_a: assert property (
      $rose(charge_enabled_o) |-> $past(deg_tif.expired) && $past(seq_r == SEQ_DEGLITCH))
      else $error("charging began without deglitch");

   enable_cond_a: assert property (
      $rose(charge_enabled_o) |-> $past(chg_en_pin_i && gate_supply_ok_i && ref_ok_i &&
                                        adapter_above_batt_i && !thermal_shutdown_i))
      else $error("charging began with a condition false");

   stop_cond_a: assert property (
      (!chg_en_pin_i || charge_ocp_i || adapter_ovp_i || thermal_shutdown_i ||
       !adapter_above_batt_i || !adapter_detect_in_above_2p4v_i) |=> !charge_enabled_o)
      else $error("charging continued after stop condition");

   soft_start_a: assert property (
      charging && step_tif.expired && (ss_level_o < SS_STEPS) |=>
         ss_level_o == $past(ss_level_o) + 4'h1)
      else $error("soft-start step missed");

   period_fixed_a: assert property (
      period_start |-> ##[PER_CHK:PER_CHK] period_start)
      else $error("switching period wrong");

   boot_refresh_a: assert property (
      charging && g_r == G_HIGH && refresh_req |=> !hs_gate_o ##4 ls_gate_o)
      else $error("bootstrap recharge not issued");

   break_make_a: assert property (
      $fell(hs_gate_o) || $fell(ls_gate_o) |-> both_off_gap)
      else $error("dead time violated");

   recharge_width_a: assert property (
      $rose(ls_gate_o) && !sync_mode_o && !refresh_r |-> recharge_pulse)
      else $error("recharge pulse width wrong");

   zero_duty_a: assert property (
      g_r == G_OFF && period_start && !duty_req_i |=> !hs_gate_o && !ls_gate_o)
      else $error("switch turned on at zero duty");

   stop_gates_a: assert property (
      $fell(charge_enabled_o) |=> !hs_gate_o && !ls_gate_o && ss_level_o == 4'h0)
      else $error("gates or soft-start not reset on stop");

endmodule

`default_nettype wire

/* File: sim/analog_front_model.sv */
// Comparator-side partner: PWM request ramp, bootstrap and charge-current comparators
`timescale 1ns/1ps
`default_nettype none

module analog_front_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Scenario controls
   input wire logic [8:0] duty_i,
   input wire logic droop_i,
   input wire logic hicur_i,
   // Comparator results
   output logic duty_req_o,
   output logic boot_low_o,
   output logic cur_below_fall_o,
   output logic cur_above_rise_o
);
   logic [8:0] ramp_r;

   // Ramp restarts every 416 cycles, in step with the converter period
   always @(posedge ref_clk_i) begin
      ramp_r <= (!nrst_i || ramp_r == 9'h19f) ? 9'h000 : ramp_r + 9'h001;
   end

   // Error level above ramp asks for the high side; a full count never falls
   assign duty_req_o = (ramp_r < duty_i);
   assign boot_low_o = droop_i;
   // Hysteresis band is never both: high current means above both thresholds
   assign cur_below_fall_o = !hicur_i;
   assign cur_above_rise_o = hicur_i;
endmodule

`default_nettype wire

/* File: sim/charger_enable_gate_sequencer_tb_top.sv */
// Self-checking bench for the charger enable and gate sequencer
`timescale 1ns/1ps
`default_nettype none

module charger_enable_gate_sequencer_tb_top;
   localparam int DET = 20;
   localparam int DGL = 40;
   localparam int SSL = 30;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic input_supply_sense = 0, ac06 = 0, ac24 = 0, abv = 1, ovp = 0, en = 1, tsd = 0, ocp = 0;
   logic droop = 0, hicur = 0, hs_q = 0, last_hs = 0;
   logic gok = 1, rok = 1;
   logic [8:0] duty = 9'h000;
   logic duty_req_i, boot_low_i, cur_below_fall_i, cur_above_rise_i;
   logic partial_bias_o, full_bias_o, current_monitor_en_o, adapter_ok_out_o, oe, ce, sm, hs, ls;
   logic [3:0] ss;
   int fail_count = 0, comparisons = 0, seed = 81799, cyc = 0, idle = 0, n, d, hsn, lsn, offn;

   always #4 ref_clk_i = ~ref_clk_i;

   charger_enable_gate_sequencer #(.DETECT_LIMIT(DET), .DEGLITCH_LIMIT(DGL), .SS_STEP_LIMIT(SSL))
   dut (.ref_clk_i, .nrst_i, .input_supply_sense_above_4v_i(input_supply_sense), .adapter_detect_in_above_0p6v_i(ac06),
      .adapter_detect_in_above_2p4v_i(ac24), .adapter_above_batt_i(abv), .adapter_ovp_i(ovp),
      .chg_en_pin_i(en), .gate_supply_ok_i(gok), .ref_ok_i(rok), .thermal_shutdown_i(tsd),
      .charge_ocp_i(ocp), .duty_req_i, .boot_low_i, .cur_below_fall_i, .cur_above_rise_i,
      .partial_bias_o, .full_bias_o, .current_monitor_en_o, .adapter_ok_out_o,
      .adapter_ok_oe_o(oe), .charge_enabled_o(ce), .ss_level_o(ss), .sync_mode_o(sm),
      .hs_gate_o(hs), .ls_gate_o(ls));

   analog_front_model partner (.ref_clk_i, .nrst_i, .duty_i(duty), .droop_i(droop),
      .hicur_i(hicur), .duty_req_o(duty_req_i), .boot_low_o(boot_low_i),
      .cur_below_fall_o(cur_below_fall_i), .cur_above_rise_o(cur_above_rise_i));

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task finish_test;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Cycles until oe (0), charge (1) or soft-start level (2) shows v; bounded
   task wait_on(input int which, input logic [3:0] v, output int c);
      c = 0;
      do begin
         @(posedge ref_clk_i);
         #1;
         c++;
      end while (((which == 0) ? {3'h0, oe} : (which == 1) ? {3'h0, ce} : ss) !== v && c < 300);
   endtask

   // Whole periods of gate activity; any window is valid since the pattern repeats
   task stats(input int periods);
      hsn = 0;
      lsn = 0;
      offn = 0;
      repeat (periods * 416) begin
         @(posedge ref_clk_i);
         #1;
         hsn += int'(hs);
         lsn += int'(ls);
         offn += int'(!hs && !ls);
      end
   endtask

   // Gate watcher samples mid-cycle once outputs settle; a rise is judged on the gap before it
   always @(negedge ref_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         finish_test();
      end
      if (hs && ls) chk("gate overlap", 0, 1);
      if ((hs && !hs_q && !last_hs) || (ls && !last_hs && 0) || (ls && last_hs && idle < 4))
         chk("dead gap", 1, idle >= 4);
      if (hs) last_hs = 1;
      else if (ls) last_hs = 0;
      idle = (hs || ls) ? 0 : idle + 1;
      hs_q = hs;
   end

   initial begin
      repeat (16) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      #1;
      chk("oe reset", 1, oe);
      chk("charge reset", 0, ce);
      chk("gates reset", 0, {hs, ls});
      chk("status drive", 0, adapter_ok_out_o);
      @(posedge ref_clk_i);
      ac06 <= 1;
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk("bias low supply", 0, full_bias_o);
      chk("oe low supply", 1, oe);
      @(posedge ref_clk_i);
      input_supply_sense <= 1;
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk("full bias", 1, full_bias_o);
      chk("monitor on", 1, current_monitor_en_o);
      @(posedge ref_clk_i);
      ac06 <= 0;
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk("partial bias", 3'h4, {partial_bias_o, full_bias_o, current_monitor_en_o});
      $display("test bias done");
      @(posedge ref_clk_i);
      ac06 <= 1;
      ac24 <= 1;
      wait_on(0, 0, n);
      chk("ok delay", DET + 1, n);
      wait_on(1, 1, n);
      chk("deglitch", DGL + 1, n);
      chk("ss start", 0, ss);
      for (int k = 1; k <= 8; k++) begin
         wait_on(2, 4'(k), n);
         chk("ss step", SSL, n);
      end
      repeat (SSL + 4) @(posedge ref_clk_i);
      #1;
      chk("ss top", 8, ss);
      $display("test power-up done");
      for (int i = 0; i < 3; i++) begin
         d = 20 + {$random(seed)} % 281;
         @(posedge ref_clk_i);
         duty <= 9'(d);
         stats(1);
         stats(1);
         chk("hs cycles", d, hsn);
         chk("ls pulse", 10, lsn);
         chk("mode", 0, sm);
      end
      @(posedge ref_clk_i);
      duty <= 9'h000;
      stats(1);
      stats(1);
      chk("zero duty", 0, hsn + lsn);
      // First window after a change is transitional, so it is skipped
      @(posedge ref_clk_i);
      duty <= 9'h1a0;
      stats(1);
      stats(1);
      chk("full duty", 416, hsn);
      @(posedge ref_clk_i);
      droop <= 1;
      stats(6);
      chk("recharge", 1, lsn >= 10 && hsn < 2496);
      // Settle the duty first so no recharge pulse straddles the mode change
      @(posedge ref_clk_i);
      droop <= 0;
      duty <= 9'h0c8;
      stats(1);
      @(posedge ref_clk_i);
      hicur <= 1;
      stats(1);
      stats(1);
      chk("sync mode", 1, sm);
      chk("sync off time", 8, offn);
      @(posedge ref_clk_i);
      hicur <= 0;
      stats(2);
      chk("nonsync mode", 0, sm);
      $display("test gates done");
      // Gate supply and reference loss also end charging, as enable terms
      for (int s = 0; s < 9; s++) begin
         @(posedge ref_clk_i);
         case (s)
            0: en <= 0;
            1: ac24 <= 0;
            2: abv <= 0;
            3: ovp <= 1;
            4: ocp <= 1;
            5: tsd <= 1;
            6: gok <= 0;
            7: rok <= 0;
            default: input_supply_sense <= 0;
         endcase
         repeat (3) @(posedge ref_clk_i);
         #1;
         chk("stop charge", 0, ce);
         chk("stop gates", 0, {hs, ls});
         if (s == 8) chk("oe no supply", 1, oe);
         @(posedge ref_clk_i);
         {en, ac24, abv, ovp, ocp, tsd, input_supply_sense, gok, rok} <= 9'h1c7;
         wait_on(1, 1, n);
         chk("re-enable", 1, ce);
         chk("ss restart", 0, ss);
      end
      $display("test stop done");
      finish_test();
   end
endmodule

`default_nettype wire
